//--- hw/active_power_pulse_engine.sv
// Design decisions made here: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "active_power_map.svh"
module active_power_pulse_engine
  import active_power_pkg::*;
#(
  parameter int unsigned HOLDOFF_CYCLES = `HOLDOFF_MS * `CLK_KHZ,
  parameter int unsigned SLOW_PULSE_CYCLES = 40000,
  parameter int unsigned FAST_PULSE_CYCLES = 40,
  parameter bit SLOW_ALTERNATE = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Asynchronous pins
  input wire logic external_clear_n_i,
  input wire logic supply_ok_i,
  input wire logic offset_filter_enable_i,
  input wire logic rate_select_hi_i,
  input wire logic rate_select_mid_i,
  input wire logic rate_select_lo_i,
  input wire logic gain_select_hi_i,
  input wire logic gain_select_lo_i,
  // Converter samples, same clock
  input wire logic signed [15:0] ch0_sample_i,
  input wire logic signed [15:0] ch1_sample_i,
  // Pulse outputs
  output logic energy_pulse_a_o,
  output logic energy_pulse_b_o,
  output logic calibration_pulse_o,
  // Product stream, never gated
  output logic signed [33:0] product_o,
  output logic product_valid_o,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o
);
  if (HOLDOFF_CYCLES < 1 || HOLDOFF_CYCLES > 32'h03ff_ffff) begin : g_bad_holdoff
    $error("HOLDOFF_CYCLES must fit the 26-bit hold-off counter");
  end
  if (SLOW_PULSE_CYCLES < 1 || SLOW_PULSE_CYCLES > 32'h0000_ffff ||
      FAST_PULSE_CYCLES < 1 || FAST_PULSE_CYCLES > 32'h0000_ffff) begin : g_bad_width
    $error("Pulse widths must lie between 1 and 65535 cycles");
  end
  localparam energy_type NOLOAD_LEVEL =
    48'((64'h1 << `FULL_SCALE_LOG2) * `NOLOAD_PPM / `PPM_DENOM);
  // Energy per pulse: full scale times 2^(N - sample divider)
  function automatic energy_type threshold(input logic [5:0] n);
    threshold = 48'h1 << (n + 6'(`FULL_SCALE_LOG2) - 6'(`SAMPLE_DIV_LOG2));
  endfunction : threshold
  // Gain codes 00/01/10/11 give shifts of 0/1/3/4
  function automatic logic [2:0] gain_shift(input logic [1:0] g);
    gain_shift = (g == 2'h0) ? 3'h0 : (g == 2'h1) ? 3'h1 : (g == 2'h2) ? 3'h3 : 3'h4;
  endfunction : gain_shift
  // Pin synchronisers: a change counts once stages two and three agree
  wire [`PIN_COUNT-1:0] pins_raw = {gain_select_hi_i, gain_select_lo_i, rate_select_hi_i,
                                    rate_select_mid_i, rate_select_lo_i,
                                    offset_filter_enable_i, supply_ok_i, external_clear_n_i};
  logic [`PIN_COUNT-1:0] sync1_q;
  logic [`PIN_COUNT-1:0] sync2_q;
  logic [`PIN_COUNT-1:0] sync3_q;
  logic [`PIN_COUNT-1:0] pins_q;
  wire [`PIN_COUNT-1:0] pin_agree = ~(sync2_q ^ sync3_q);
  wire [`PIN_COUNT-1:0] pins_d = (pin_agree & sync3_q) | (~pin_agree & pins_q);
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      pins_q <= '0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pins_q <= pins_d;
    end
  end
  wire core_rst_b = rst_b_i & pins_q[`PIN_CLEAR_N] & pins_q[`PIN_SUPPLY_OK];
  wire filter_on = pins_q[`PIN_FILTER_EN];
  wire [2:0] rate_sel = pins_q[`PIN_RATE_HI:`PIN_RATE_LO];
  wire [1:0] gain_sel = pins_q[`PIN_GAIN_HI:`PIN_GAIN_LO];
  // sample strobe every 256 clocks, staged down the pipeline
  logic [`SAMPLE_DIV_LOG2-1:0] div_q;
  logic [2:0] stb_q;
  wire div_wrap = (div_q == {`SAMPLE_DIV_LOG2{1'b1}});
  always_ff @(posedge clk_i) begin
    if (!core_rst_b) begin
      div_q <= '0;
      stb_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
      stb_q <= {stb_q[1:0], div_wrap};
    end
  end
  // both filters take the same strobe and inputs at once
  channel_type ch0_ext;
  channel_type ch1_ext;
  channel_type ch0_hp;
  channel_type ch1_hp;
  channel_type ch0_raw_q;
  channel_type ch1_raw_q;
  assign ch0_ext = {ch0_sample_i[15], ch0_sample_i};
  assign ch1_ext = {ch1_sample_i[15], ch1_sample_i};
  // shift of 9 puts the corner near 4.45 Hz at 3.58 MHz
  first_order_iir #(.WIDTH(17), .SHIFT(`OFFSET_FILTER_SHIFT), .HIGHPASS(1'b1)) u_hp0 (
    .clk_i(clk_i),
    .rst_b_i(core_rst_b),
    .strobe_i(div_wrap),
    .x_i(ch0_ext),
    .y_o(ch0_hp)
  );
  first_order_iir #(.WIDTH(17), .SHIFT(`OFFSET_FILTER_SHIFT), .HIGHPASS(1'b1)) u_hp1 (
    .clk_i(clk_i),
    .rst_b_i(core_rst_b),
    .strobe_i(div_wrap),
    .x_i(ch1_ext),
    .y_o(ch1_hp)
  );
  wire signed [16:0] ch0_sel = filter_on ? ch0_hp : ch0_raw_q;
  wire signed [16:0] ch1_sel = filter_on ? ch1_hp : ch1_raw_q;
  // instantaneous power from the selected channels
  wire signed [33:0] product_d = ch0_sel * ch1_sel;
  logic signed [33:0] product_q;
  // gain scales power and every output rate
  wire signed [37:0] scaled_d = 38'(product_q) <<< gain_shift(gain_sel);
  power_type power_in;
  power_type avg_power;
  always_ff @(posedge clk_i) begin
    if (!core_rst_b) begin
      ch0_raw_q <= '0;
      ch1_raw_q <= '0;
      product_q <= '0;
    end else begin
      if (div_wrap) begin
        ch0_raw_q <= ch0_ext;
        ch1_raw_q <= ch1_ext;
      end
      if (stb_q[0]) begin
        product_q <= product_d;
      end
    end
  end
  assign power_in = scaled_d;
  // one-pole IIR for the mean power
  // shift of 8 puts the corner near 8.9 Hz
  first_order_iir #(.WIDTH(38), .SHIFT(`POWER_LOWPASS_SHIFT), .HIGHPASS(1'b0)) u_power_lowpass (
    .clk_i(clk_i),
    .rst_b_i(core_rst_b),
    .strobe_i(stb_q[1]),
    .x_i(power_in),
    .y_o(avg_power)
  );
  // product leaves before any creep gating
  assign product_o = product_q;
  assign product_valid_o = stb_q[1];
  // accumulation waits out the settling samples
  logic [1:0] settle_q;
  wire settled = (settle_q == `SETTLE_SAMPLES);
  // hold-off restarts on every reset release
  logic [25:0] holdoff_q;
  wire holdoff = (holdoff_q != 26'(HOLDOFF_CYCLES));
  always_ff @(posedge clk_i) begin
    if (!core_rst_b) begin
      settle_q <= '0;
      holdoff_q <= '0;
    end else begin
      if (stb_q[2] && !settled) begin
        settle_q <= settle_q + 1'b1;
      end
      if (holdoff) begin
        holdoff_q <= holdoff_q + 1'b1;
      end
    end
  end
  // slow constant is MCLK/2^(21 - rate_sel[1:0])
  wire [5:0] slow_log2 = 6'(`SLOW_BASE_LOG2) - {4'h0, rate_sel[1:0]};
  // fast constant from all three selects
  wire [5:0] fast_log2 = (rate_sel == `CAL_RATE_SEL) ? 6'(`FAST_CAL_LOG2) :
                         rate_sel[2] ? 6'(`FAST_HIGH_LOG2) : 6'(`FAST_LOW_LOG2);
  // slow threshold is 2^2 or more times the fast one
  // slow energy per pulse follows the selects
  wire [47:0] slow_thr = threshold(slow_log2);
  wire [47:0] fast_thr = threshold(fast_log2);
  // creep level is 15 ppm of full-scale power
  // calibration select lifts the creep gate
  wire power_pos = !avg_power[37];
  wire [47:0] power_mag = power_pos ? {10'h0, avg_power} : 48'h0;
  wire noload = (rate_sel != `CAL_RATE_SEL) && (power_mag < NOLOAD_LEVEL);
  wire accumulate = stb_q[2] && settled && !noload;
  // accumulate and emit one pulse per crossing
  logic [47:0] slow_acc_q;
  logic [47:0] fast_acc_q;
  wire [47:0] slow_sum = slow_acc_q + power_mag;
  wire [47:0] fast_sum = fast_acc_q + power_mag;
  wire slow_cross = accumulate && (slow_sum >= slow_thr);
  wire fast_cross = accumulate && (fast_sum >= fast_thr);
  // accumulators clear with the core reset
  always_ff @(posedge clk_i) begin
    if (!core_rst_b) begin
      slow_acc_q <= '0;
      fast_acc_q <= '0;
    end else if (accumulate) begin
      slow_acc_q <= slow_cross ? slow_sum - slow_thr : slow_sum;
      fast_acc_q <= fast_cross ? fast_sum - fast_thr : fast_sum;
    end
  end
  // Pulse timers; a crossing during a pulse restarts its timer
  logic pulse_en_q;
  wire fire_ok = !holdoff && pulse_en_q;
  logic [15:0] slow_tmr_q;
  logic [15:0] fast_tmr_q;
  slow_phase_type phase_q;
  logic pulse_a_q;
  logic pulse_b_q;
  logic pulse_cal_q;
  wire slow_fire = slow_cross && fire_ok;
  wire fast_fire = fast_cross && fire_ok;
  // width and alternation come from parameters
  always_ff @(posedge clk_i) begin
    if (!core_rst_b) begin
      slow_tmr_q <= '0;
      fast_tmr_q <= '0;
      phase_q <= PHASE_A;
      pulse_a_q <= 1'b0;
      pulse_b_q <= 1'b0;
      pulse_cal_q <= 1'b0;
    end else begin
      if (slow_fire) begin
        slow_tmr_q <= 16'(SLOW_PULSE_CYCLES);
        pulse_a_q <= !SLOW_ALTERNATE || (phase_q == PHASE_A);
        pulse_b_q <= !SLOW_ALTERNATE || (phase_q == PHASE_B);
        phase_q <= (phase_q == PHASE_A) ? PHASE_B : PHASE_A;
      end else if (slow_tmr_q != 16'h0) begin
        slow_tmr_q <= slow_tmr_q - 1'b1;
      end else begin
        pulse_a_q <= 1'b0;
        pulse_b_q <= 1'b0;
      end
      if (fast_fire) begin
        fast_tmr_q <= 16'(FAST_PULSE_CYCLES);
        pulse_cal_q <= 1'b1;
      end else if (fast_tmr_q != 16'h0) begin
        fast_tmr_q <= fast_tmr_q - 1'b1;
      end else begin
        pulse_cal_q <= 1'b0;
      end
    end
  end
  assign energy_pulse_a_o = pulse_a_q;
  assign energy_pulse_b_o = pulse_b_q;
  assign calibration_pulse_o = pulse_cal_q;
  // Bus: address phase captured, one wait cycle, then data
  logic pend_q;
  logic pend_write_q;
  logic [7:0] addr_q;
  logic ready_q;
  logic [31:0] rdata_q;
  logic [31:0] slow_count_q;
  logic [31:0] fast_count_q;
  wire take = hsel_i && htrans_i[1] && hready_i;
  wire wr_ctrl = pend_q && pend_write_q && (addr_q == `REG_CTRL_OFS);
  wire count_clear = wr_ctrl && hwdata_i[`CTRL_COUNT_CLEAR_BIT];
  wire [31:0] ctrl_word = {30'h0, pulse_en_q, 1'b0};
  wire [31:0] status_word = {28'h0, filter_on, !settled, noload, holdoff};
  wire [31:0] rd_word = (addr_q == `REG_CTRL_OFS) ? ctrl_word :
                        (addr_q == `REG_STATUS_OFS) ? status_word :
                        (addr_q == `REG_POWER_OFS) ? avg_power[37:6] :
                        (addr_q == `REG_SLOW_COUNT_OFS) ? slow_count_q :
                        (addr_q == `REG_FAST_COUNT_OFS) ? fast_count_q : 32'h0;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pend_q <= 1'b0;
      pend_write_q <= 1'b0;
      addr_q <= '0;
      ready_q <= 1'b1;
      rdata_q <= '0;
    end else begin
      pend_q <= take;
      ready_q <= !take;
      if (take) begin
        pend_write_q <= hwrite_i;
        addr_q <= {haddr_i[7:2], 2'b00};
      end
      if (pend_q && !pend_write_q) begin
        rdata_q <= rd_word;
      end
    end
  end
  // Control and counters; a pulse in the clear cycle still counts
  always_ff @(posedge clk_i) begin
    if (!core_rst_b) begin
      pulse_en_q <= 1'(`CTRL_RESET_VALUE >> `CTRL_PULSE_ENABLE_BIT);
      slow_count_q <= '0;
      fast_count_q <= '0;
    end else begin
      if (wr_ctrl) begin
        pulse_en_q <= hwdata_i[`CTRL_PULSE_ENABLE_BIT];
      end
      slow_count_q <= (count_clear ? 32'h0 : slow_count_q) + {31'h0, slow_fire};
      fast_count_q <= (count_clear ? 32'h0 : fast_count_q) + {31'h0, fast_fire};
    end
  end
  assign hrdata_o = rdata_q;
  assign hreadyout_o = ready_q;
  assign hresp_o = 1'b0;
endmodule : active_power_pulse_engine
`default_nettype wire

//--- hw/active_power_map.svh
`ifndef ACTIVE_POWER_MAP_SVH
`define ACTIVE_POWER_MAP_SVH

// Register byte offsets
`define REG_CTRL_OFS 8'h00
`define REG_STATUS_OFS 8'h04
`define REG_POWER_OFS 8'h08
`define REG_SLOW_COUNT_OFS 8'h0c
`define REG_FAST_COUNT_OFS 8'h10

// Control fields
`define CTRL_COUNT_CLEAR_BIT 0
`define CTRL_PULSE_ENABLE_BIT 1
`define CTRL_RESET_VALUE 32'h0000_0002

// Status fields
`define STAT_HOLDOFF_BIT 0
`define STAT_NOLOAD_BIT 1
`define STAT_SETTLING_BIT 2
`define STAT_FILTER_ON_BIT 3

// Positions in the synchronised pin vector
`define PIN_COUNT 8
`define PIN_CLEAR_N 0
`define PIN_SUPPLY_OK 1
`define PIN_FILTER_EN 2
`define PIN_RATE_LO 3
`define PIN_RATE_HI 5
`define PIN_GAIN_LO 6
`define PIN_GAIN_HI 7

// Signal path
`define SAMPLE_DIV_LOG2 8
`define SETTLE_SAMPLES 2'h3
`define OFFSET_FILTER_SHIFT 9
`define POWER_LOWPASS_SHIFT 8
`define FULL_SCALE_LOG2 30
`define SLOW_BASE_LOG2 21
`define FAST_LOW_LOG2 15
`define FAST_CAL_LOG2 7
`define FAST_HIGH_LOG2 16
`define CAL_RATE_SEL 3'h3
`define NOLOAD_PPM 15
`define PPM_DENOM 1000000

// Timing
`define HOLDOFF_MS 1000
`define CLK_KHZ 40000

`endif

//--- hw/active_power_pkg.sv
package active_power_pkg;
  typedef logic signed [15:0] sample_type;
  typedef logic signed [16:0] channel_type;
  typedef logic signed [37:0] power_type;
  typedef logic [47:0] energy_type;
  typedef enum logic {PHASE_A, PHASE_B} slow_phase_type;
endpackage : active_power_pkg

//--- hw/first_order_iir.sv
`timescale 1ns/100ps
`default_nettype none
module first_order_iir #(
  parameter int WIDTH = 17,
  parameter int SHIFT = 9,
  parameter bit HIGHPASS = 1'b1
) (
  // Clock and core reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Sample stream
  input wire logic strobe_i,
  input wire logic signed [WIDTH-1:0] x_i,
  output logic signed [WIDTH-1:0] y_o
);
  localparam int AW = WIDTH + SHIFT + 1;

  if (WIDTH < 2 || SHIFT < 1) begin : g_bad_param
    $error("first_order_iir needs WIDTH >= 2 and SHIFT >= 1");
  end

  logic signed [AW-1:0] acc_q;
  logic signed [AW-1:0] acc_d;
  logic signed [WIDTH-1:0] y_q;
  logic signed [WIDTH-1:0] y_d;

  // Accumulator holds the low-pass value scaled by 2^SHIFT
  wire signed [AW-1:0] x_ext = {{(SHIFT + 1){x_i[WIDTH-1]}}, x_i};
  wire signed [AW-1:0] lp_full = acc_q >>> SHIFT;
  wire signed [WIDTH-1:0] lp = lp_full[WIDTH-1:0];
  wire signed [WIDTH:0] diff = {x_i[WIDTH-1], x_i} - {lp[WIDTH-1], lp};

  // One-pole update; high-pass is input minus the tracked mean
  assign acc_d = acc_q + x_ext - lp_full;
  assign y_d = HIGHPASS ? diff[WIDTH-1:0] : lp;
  assign y_o = y_q;

  // State advances only on the shared sample strobe
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      acc_q <= '0;
      y_q <= '0;
    end else if (strobe_i) begin
      acc_q <= acc_d;
      y_q <= y_d;
    end
  end
endmodule : first_order_iir
`default_nettype wire

//--- dv/active_power_pulse_engine_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module active_power_pulse_engine_monitor #(
  parameter int unsigned HOLDOFF_CYCLES = 100,
  parameter int unsigned SLOW_PULSE_CYCLES = 8,
  parameter int unsigned FAST_PULSE_CYCLES = 40
) (
  // Clock, reset and pins
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic external_clear_n_i,
  input wire logic supply_ok_i,
  // Outputs
  input wire logic energy_pulse_a_o,
  input wire logic energy_pulse_b_o,
  input wire logic calibration_pulse_o,
  input wire logic signed [33:0] product_o,
  input wire logic product_valid_o,
  // Bus
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hready_i,
  input wire logic hreadyout_o
);
  logic pins_ok;
  logic seen_q;
  logic [8:0] gap_q;
  logic [31:0] up_q;
  logic [31:0] cal_run_q;
  logic [31:0] slow_run_q;
  // Any reset source restarts the reference counts
  assign pins_ok = rst_b_i && external_clear_n_i && supply_ok_i;
  // Up count saturates so a long run never wraps into a false hold-off failure
  always_ff @(posedge clk_i) begin
    seen_q <= pins_ok && (seen_q || product_valid_o);
    gap_q <= product_valid_o ? 9'h000 : gap_q + 9'h001;
    up_q <= !pins_ok ? 32'h0 : (up_q == 32'hffff_ffff ? up_q : up_q + 32'h1);
    cal_run_q <= calibration_pulse_o ? cal_run_q + 32'h1 : 32'h0;
    slow_run_q <= energy_pulse_a_o ? slow_run_q + 32'h1 : 32'h0;
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  a_valid_spacing: assert property (
    product_valid_o && seen_q |-> gap_q == 9'h0ff)
    else $error("product spacing wrong");
  a_holdoff_quiet: assert property (
    $rose(calibration_pulse_o) || $rose(energy_pulse_a_o) || $rose(energy_pulse_b_o)
    |-> up_q >= HOLDOFF_CYCLES)
    else $error("pulse inside hold-off");
  a_supply_reset: assert property (
    !supply_ok_i [*7] |-> !energy_pulse_a_o && !energy_pulse_b_o
    && !calibration_pulse_o && !product_valid_o && product_o == 34'sh0)
    else $error("supply drop left logic running");
  a_clear_reset: assert property (
    !external_clear_n_i [*7] |-> !energy_pulse_a_o && !calibration_pulse_o
    && !product_valid_o)
    else $error("clear pin left logic running");
  a_slow_exclusive: assert property (
    !(energy_pulse_a_o && energy_pulse_b_o))
    else $error("slow outputs high together");
  a_cal_width: assert property (
    $fell(calibration_pulse_o) && pins_ok |-> cal_run_q == FAST_PULSE_CYCLES + 1)
    else $error("calibration pulse width wrong");
  a_slow_width: assert property (
    $fell(energy_pulse_a_o) && pins_ok |-> slow_run_q == SLOW_PULSE_CYCLES + 1)
    else $error("slow pulse width wrong");
  // Bus data phase of two cycles
  a_bus_answer: assert property (
    hsel_i && htrans_i[1] && hready_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("bus answer timing wrong");
endmodule : active_power_pulse_engine_monitor
`default_nettype wire

//--- dv/pulse_counter_model.sv
`timescale 1ns/100ps
`default_nettype none
module pulse_counter_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Pulse lines from the meter
  input wire logic slow_a_i,
  input wire logic slow_b_i,
  input wire logic cal_i,
  // Tallies
  output logic [31:0] slow_count_o,
  output logic [31:0] cal_count_o,
  output logic first_a_o
);
  logic a_q;
  logic b_q;
  logic c_q;
  // Counts leading edges, as a stepper or counter would step once per pulse
  always_ff @(posedge clk_i) begin
    a_q <= slow_a_i;
    b_q <= slow_b_i;
    c_q <= cal_i;
    if (!rst_b_i) begin
      slow_count_o <= 32'h0;
      cal_count_o <= 32'h0;
      first_a_o <= 1'b0;
    end else begin
      if ((slow_a_i && !a_q) || (slow_b_i && !b_q)) slow_count_o <= slow_count_o + 32'h1;
      if (slow_count_o == 32'h0 && slow_a_i && !a_q) first_a_o <= 1'b1;
      if (cal_i && !c_q) cal_count_o <= cal_count_o + 32'h1;
    end
  end
endmodule : pulse_counter_model
`default_nettype wire

//--- dv/tb_active_power_pulse_engine.sv
`timescale 1ns/100ps
`default_nettype none
`include "active_power_map.svh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_count++; \
  $display("wrong value at %0t: got %h want %h", $time, got, exp); end end
module tb_active_power_pulse_engine;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic clr_n = 1'b1;
  logic sup_ok = 1'b1;
  logic filt_en = 1'b0;
  logic [2:0] rate = 3'h3;
  logic [1:0] gain = 2'h3;
  logic signed [15:0] ch0 = 16'sh7fff;
  logic signed [15:0] ch1 = 16'sh7fff;
  logic pa;
  logic pb;
  logic pc;
  logic pv;
  logic signed [33:0] prod;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic [31:0] slow_n;
  logic [31:0] cal_n;
  logic first_a;
  logic [31:0] rd;
  logic [31:0] base;
  int err_count = 0;
  int checked = 0;
  // Short hold-off and slow width keep the run brief
  active_power_pulse_engine #(.HOLDOFF_CYCLES(100), .SLOW_PULSE_CYCLES(8)) u_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .external_clear_n_i(clr_n), .supply_ok_i(sup_ok),
    .offset_filter_enable_i(filt_en), .rate_select_hi_i(rate[2]),
    .rate_select_mid_i(rate[1]), .rate_select_lo_i(rate[0]), .gain_select_hi_i(gain[1]),
    .gain_select_lo_i(gain[0]), .ch0_sample_i(ch0), .ch1_sample_i(ch1),
    .energy_pulse_a_o(pa), .energy_pulse_b_o(pb), .calibration_pulse_o(pc),
    .product_o(prod), .product_valid_o(pv), .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp));
  pulse_counter_model u_counter (.clk_i(clk_i), .rst_b_i(rst_b_i), .slow_a_i(pa),
    .slow_b_i(pb), .cal_i(pc), .slow_count_o(slow_n), .cal_count_o(cal_n),
    .first_a_o(first_a));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic summarize;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  // Bounded wait for the ready sampled at an edge
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge clk_i);
    while (hready !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 50) err_count++;
  endtask : wait_ready
  // One single word transfer; read data lands in rd
  task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
    @(posedge clk_i);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, ofs};
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask : xfer
  task automatic wait_pv;
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pv !== 1'b1 && n < 600);
  endtask : wait_pv
  // Waits until the chosen tally moves, or the limit runs out
  task automatic wait_more(input bit slow, input int lim);
    logic [31:0] s;
    int n;
    s = slow ? slow_n : cal_n;
    n = 0;
    while ((slow ? slow_n : cal_n) === s && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask : wait_more
  // Watchdog: well past the slow-pulse wait, still under the cycle budget
  initial begin
    #2_250_000;
    err_count++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    xfer(1'b0, `REG_CTRL_OFS, 32'h0);
    `CHK(rd, `CTRL_RESET_VALUE)
    xfer(1'b0, `REG_STATUS_OFS, 32'h0);
    `CHK(rd[`STAT_HOLDOFF_BIT], 1'b1)
    `CHK(rd[`STAT_FILTER_ON_BIT], 1'b0)
    // Unmapped place ignores writes
    xfer(1'b1, 8'h40, 32'hffff_ffff);
    xfer(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h0)
    repeat (6) wait_pv();
    `CHK(prod, 34'sh3fff_0001)
    // code 011 drives the fast output
    wait_more(1'b0, 5000);
    `CHK(cal_n > 32'h0, 1'b1)
    xfer(1'b0, `REG_STATUS_OFS, 32'h0);
    `CHK(rd[`STAT_NOLOAD_BIT], 1'b0)
    // slow output, A first, fewer pulses
    wait_more(1'b1, 70000);
    `CHK(first_a, 1'b1)
    `CHK(cal_n > 32'h40 * slow_n, 1'b1)
    xfer(1'b0, `REG_SLOW_COUNT_OFS, 32'h0);
    `CHK(rd, slow_n)
    // Count clear is self clearing
    xfer(1'b1, `REG_CTRL_OFS, 32'h3);
    xfer(1'b0, `REG_SLOW_COUNT_OFS, 32'h0);
    `CHK(rd, 32'h0)
    xfer(1'b0, `REG_CTRL_OFS, 32'h0);
    `CHK(rd, 32'h2)
    // Pulse enable off stops the fast output
    xfer(1'b1, `REG_CTRL_OFS, 32'h0);
    repeat (2) wait_pv();
    base = cal_n;
    repeat (8) wait_pv();
    `CHK(cal_n, base)
    // supply drop clears like the clear pin
    sup_ok <= 1'b0;
    rate <= 3'h0;
    gain <= 2'h0;
    ch0 <= 16'sh0064;
    ch1 <= 16'sh0064;
    repeat (10) @(posedge clk_i);
    xfer(1'b0, `REG_POWER_OFS, 32'h0);
    `CHK(rd, 32'h0)
    xfer(1'b0, `REG_CTRL_OFS, 32'h0);
    `CHK(rd, `CTRL_RESET_VALUE)
    sup_ok <= 1'b1;
    repeat (10) @(posedge clk_i);
    xfer(1'b0, `REG_STATUS_OFS, 32'h0);
    `CHK(rd[`STAT_HOLDOFF_BIT], 1'b1)
    // small load gated except on code 011
    repeat (12) wait_pv();
    xfer(1'b0, `REG_STATUS_OFS, 32'h0);
    `CHK(rd[`STAT_NOLOAD_BIT], 1'b1)
    rate <= 3'h3;
    filt_en <= 1'b1;
    repeat (2) wait_pv();
    xfer(1'b0, `REG_STATUS_OFS, 32'h0);
    `CHK(rd[`STAT_NOLOAD_BIT], 1'b0)
    `CHK(rd[`STAT_FILTER_ON_BIT], 1'b1)
    // clear pin empties the power filter
    clr_n <= 1'b0;
    repeat (10) @(posedge clk_i);
    xfer(1'b0, `REG_POWER_OFS, 32'h0);
    `CHK(rd, 32'h0)
    clr_n <= 1'b1;
    repeat (10) @(posedge clk_i);
    summarize();
  end
endmodule : tb_active_power_pulse_engine
bind active_power_pulse_engine active_power_pulse_engine_monitor #(
  .HOLDOFF_CYCLES(HOLDOFF_CYCLES), .SLOW_PULSE_CYCLES(SLOW_PULSE_CYCLES),
  .FAST_PULSE_CYCLES(FAST_PULSE_CYCLES)) u_mon (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .external_clear_n_i(external_clear_n_i),
  .supply_ok_i(supply_ok_i), .energy_pulse_a_o(energy_pulse_a_o),
  .energy_pulse_b_o(energy_pulse_b_o), .calibration_pulse_o(calibration_pulse_o),
  .product_o(product_o), .product_valid_o(product_valid_o), .hsel_i(hsel_i),
  .htrans_i(htrans_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o));
`default_nettype wire
